// ### hdl/guard_ctrl_regs.vh
/*
 Register map, field positions, reset values and timing figures of the
 guard sensor output controller. Assumes a 100 MHz ref_clk and an APB master.
*/
//
// Operation
// - Outputs on only with inputs and safe actuator
// - Outside zone: outputs off, steady yellow
// - Safe zone entry: outputs on, steady green
// - Limit zone: outputs kept, yellow flashing
// - Leaving limit zone: outputs off, yellow
// - Supply watched, self-test run cyclically
// - Input and position results feed decision
// - Outputs switched, shorts and faults detected
// - Contactor feedback must follow output changes
// - Learn request starts actuator replacement
// - Signalling output shows guard closed, variant sense
// - Chain end variant, at most 32 sensors
// - Error state red, code shown by sequence
// - Learning shows purple indication
// - Learned actuator replaces the old code
`ifndef GUARD_CTRL_REGS_VH
`define GUARD_CTRL_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CTRL      12'h000
`define ADDR_STATUS    12'h004
`define ADDR_IRQ_STAT  12'h008
`define ADDR_IRQ_MASK  12'h00c
`define ADDR_CODE      12'h010
`define ADDR_CHAIN     12'h014

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_EDM       0
`define CTRL_LEARN     1
`define CTRL_INPUTS    2
`define CTRL_INVERT    3
`define CTRL_CLEAR     4
`define CTRL_RST       5'h04

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define IRQ_ON         0
`define IRQ_OFF        1
`define IRQ_FAULT      2
`define IRQ_LEARNED    3

// ----------------------------------------
// Fault codes and other values
// ----------------------------------------
`define FLT_NONE       3'h0
`define FLT_SUPPLY     3'h1
`define FLT_SELFTEST   3'h2
`define FLT_OUTPUT     3'h3
`define FLT_FEEDBACK   3'h4
`define FLT_CHAIN      3'h5
`define CODE_RST       16'h0000
`define CHAIN_RST      6'h01
`define CHAIN_MAX      6'h20

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ        100
`define SELFTEST_US    10000
`define ST_WAIT_US     1000
`define FEEDBACK_US    100000
`define BLINK_US       250000
`define OUT_SETTLE_CYC 4'h4

`endif

// ### hdl/led_indicator.v
/*
 Status indicator sequencer: maps the controller mode onto red, green and
 blue lamp drives. Assumes one mode flag high at a time.
*/
`timescale 1ns/1ns
`include "guard_ctrl_regs.vh"
module led_indicator #(
	parameter BLINK_CYC = `BLINK_US * `CLK_MHZ
) (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       show_green,
	input  wire       show_yellow,
	input  wire       flash_yellow,
	input  wire       show_purple,
	input  wire       show_red,
	input  wire [2:0] fault_code,
	output reg        led_red,
	output reg        led_green,
	output reg        led_blue
);

	reg [31:0] tick_reg;
	reg        phase_reg;
	reg [3:0]  pulse_reg;
	reg        r_next;
	reg        g_next;
	reg        b_next;

	// Half-period blink clock; pulse counter spans code pulses plus a gap
	always @(posedge ref_clk) begin
		if (rst) begin
			tick_reg  <= 32'h0;
			phase_reg <= 1'b0;
			pulse_reg <= 4'h0;
		end else if (tick_reg == BLINK_CYC - 1) begin
			tick_reg  <= 32'h0;
			phase_reg <= ~phase_reg;
			if (phase_reg) begin
				if (pulse_reg >= {1'b0, fault_code} + 4'h1)
					pulse_reg <= 4'h0;
				else
					pulse_reg <= pulse_reg + 4'h1;
			end
		end else begin
			tick_reg <= tick_reg + 32'h1;
		end
	end

	// Colour choice; the gap after the red pulses shows yellow so the
	// operator can count pulses even from a distance
	always @* begin
		r_next = 1'b0;
		g_next = 1'b0;
		b_next = 1'b0;
		if (show_red) begin
			if (pulse_reg < {1'b0, fault_code})
				r_next = phase_reg;
			else begin
				r_next = 1'b1;
				g_next = 1'b1;
			end
		end else if (show_purple) begin
			r_next = 1'b1;
			b_next = 1'b1;
		end else if (show_green) begin
			g_next = 1'b1;
		end else if (flash_yellow) begin
			r_next = phase_reg;
			g_next = phase_reg;
		end else if (show_yellow) begin
			r_next = 1'b1;
			g_next = 1'b1;
		end
	end

	// Lamp drives from flip-flops
	always @(posedge ref_clk) begin
		if (rst) begin
			led_red   <= 1'b0;
			led_green <= 1'b0;
			led_blue  <= 1'b0;
		end else begin
			led_red   <= r_next;
			led_green <= g_next;
			led_blue  <= b_next;
		end
	end

endmodule

// ### hdl/guard_sensor_output_controller.v
/*
 Guard sensor output controller: zone state machine, supervision,
 output diagnosis, contactor feedback, actuator learning, APB registers
 and interrupt. Assumes the sensing front end gives zone flags and the
 read actuator code synchronous to ref_clk.
*/
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "guard_ctrl_regs.vh"
module guard_sensor_output_controller #(
	parameter SELFTEST_CYC = `SELFTEST_US * `CLK_MHZ,
	parameter ST_WAIT_CYC  = `ST_WAIT_US * `CLK_MHZ,
	parameter FEEDBACK_CYC = `FEEDBACK_US * `CLK_MHZ,
	parameter BLINK_CYC    = `BLINK_US * `CLK_MHZ
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        supply_ok,
	output reg         selftest_req,
	input  wire        selftest_done,
	input  wire        selftest_pass,
	input  wire [1:0]  safety_inputs,
	input  wire        zone_safe,
	input  wire        zone_limit,
	input  wire        actuator_present,
	input  wire [15:0] actuator_code,
	input  wire [1:0]  output_readback,
	input  wire        contactor_feedback_input,
	input  wire        learn_request_input,
	output reg  [1:0]  safety_outputs,
	output reg         signal_output,
	output wire        led_red,
	output wire        led_green,
	output wire        led_blue,
	output wire        irq
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam S_IDLE  = 5'b00001;
	localparam S_SAFE  = 5'b00010;
	localparam S_LIMIT = 5'b00100;
	localparam S_LEARN = 5'b01000;
	localparam S_FAULT = 5'b10000;

	reg [4:0]  state_reg;
	reg [4:0]  state_next;
	reg [4:0]  ctrl_reg;
	reg [3:0]  irq_stat_reg;
	reg [3:0]  irq_mask_reg;
	reg [15:0] code_reg;
	reg [5:0]  chain_reg;
	reg [2:0]  fault_reg;
	reg [2:0]  fault_next;
	reg [31:0] st_cnt_reg;
	reg        st_wait_reg;
	reg [31:0] fb_cnt_reg;
	reg [3:0]  settle_reg;
	reg        learn_req_d;
	reg        st_fail;
	reg        ev_learned;
	wire       wr_en;
	wire       rd_setup;
	wire       addr_ok;
	wire       inputs_ok;
	wire       code_ok;
	wire       outs_on;
	wire       out_fault;
	wire       fb_fault;
	wire       chain_fault;
	wire       any_fault;
	wire       learn_edge;
	wire [3:0] ev;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Zero wait states; unmapped or unaligned address answers with an error
	assign addr_ok  = (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS) ||
			(paddr == `ADDR_IRQ_STAT) || (paddr == `ADDR_IRQ_MASK) ||
			(paddr == `ADDR_CODE) || (paddr == `ADDR_CHAIN);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~addr_ok;
	assign wr_en    = psel & penable & pwrite & addr_ok;
	assign rd_setup = psel & ~penable & ~pwrite;

	// Read data captured in the setup cycle, valid during the access phase
	always @(posedge ref_clk) begin
		if (rst) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			case (paddr)
			`ADDR_CTRL:     prdata <= {27'h0, ctrl_reg};
			`ADDR_STATUS:   prdata <= {16'h0, 3'h0, fault_reg, safety_outputs,
					signal_output, 1'b0, 1'b0, state_reg};
			`ADDR_IRQ_STAT: prdata <= {28'h0, irq_stat_reg};
			`ADDR_IRQ_MASK: prdata <= {28'h0, irq_mask_reg};
			`ADDR_CODE:     prdata <= {16'h0, code_reg};
			`ADDR_CHAIN:    prdata <= {26'h0, chain_reg};
			default:        prdata <= 32'h0;
			endcase
		end
	end

	// Control, mask and chain registers; the clear bit acts once
	always @(posedge ref_clk) begin
		if (rst) begin
			ctrl_reg     <= `CTRL_RST;
			irq_mask_reg <= 4'h0;
			chain_reg    <= `CHAIN_RST;
		end else begin
			ctrl_reg[`CTRL_CLEAR] <= 1'b0;
			if (wr_en && paddr == `ADDR_CTRL)
				ctrl_reg <= pwdata[4:0];
			if (wr_en && paddr == `ADDR_IRQ_MASK)
				irq_mask_reg <= pwdata[3:0];
			if (wr_en && paddr == `ADDR_CHAIN)
				chain_reg <= pwdata[5:0];
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	assign ev = {ev_learned,
			(state_next == S_FAULT) && (state_reg != S_FAULT),
			outs_on & ~(state_next == S_SAFE || state_next == S_LIMIT),
			~outs_on & (state_next == S_SAFE || state_next == S_LIMIT)};

	// Write one to clear; a new event in the same cycle stays set
	always @(posedge ref_clk) begin
		if (rst)
			irq_stat_reg <= 4'h0;
		else if (wr_en && paddr == `ADDR_IRQ_STAT)
			irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | ev;
		else
			irq_stat_reg <= irq_stat_reg | ev;
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	// ----------------------------------------
	// Supervision: supply and cyclic self-test
	// ----------------------------------------
	// A missing answer counts as a failed test, so a dead tester cannot hide
	always @(posedge ref_clk) begin
		if (rst) begin
			st_cnt_reg   <= 32'h0;
			st_wait_reg  <= 1'b0;
			selftest_req <= 1'b0;
			st_fail      <= 1'b0;
		end else begin
			selftest_req <= 1'b0;
			st_fail      <= 1'b0;
			if (!st_wait_reg) begin
				if (st_cnt_reg == SELFTEST_CYC - 1) begin
					st_cnt_reg   <= 32'h0;
					st_wait_reg  <= 1'b1;
					selftest_req <= 1'b1;
				end else begin
					st_cnt_reg <= st_cnt_reg + 32'h1;
				end
			end else if (selftest_done) begin
				st_wait_reg <= 1'b0;
				st_cnt_reg  <= 32'h0;
				st_fail     <= ~selftest_pass;
			end else if (st_cnt_reg == ST_WAIT_CYC - 1) begin
				st_wait_reg <= 1'b0;
				st_cnt_reg  <= 32'h0;
				st_fail     <= 1'b1;
			end else begin
				st_cnt_reg <= st_cnt_reg + 32'h1;
			end
		end
	end

	// ----------------------------------------
	// Input watch and actuator position
	// ----------------------------------------
	assign inputs_ok = ~ctrl_reg[`CTRL_INPUTS] | (&safety_inputs);
	assign code_ok   = actuator_present & (actuator_code == code_reg);
	assign outs_on   = safety_outputs[0] | safety_outputs[1];

	// ----------------------------------------
	// Output diagnosis and contactor feedback
	// ----------------------------------------
	// Readback is ignored for a few cycles after a switch to let the
	// driver settle; after that any mismatch is a short or a stuck output
	always @(posedge ref_clk) begin
		if (rst)
			settle_reg <= 4'h0;
		else if ((state_next == S_SAFE || state_next == S_LIMIT) != outs_on)
			settle_reg <= 4'h0;
		else if (settle_reg != `OUT_SETTLE_CYC)
			settle_reg <= settle_reg + 4'h1;
	end

	assign out_fault = (settle_reg == `OUT_SETTLE_CYC) &&
			(output_readback != safety_outputs);

	// NC feedback must read low while outputs are on, high while off
	always @(posedge ref_clk) begin
		if (rst)
			fb_cnt_reg <= 32'h0;
		else if (!ctrl_reg[`CTRL_EDM] || (contactor_feedback_input != outs_on))
			fb_cnt_reg <= 32'h0;
		else if (fb_cnt_reg != FEEDBACK_CYC)
			fb_cnt_reg <= fb_cnt_reg + 32'h1;
	end

	assign fb_fault    = (fb_cnt_reg == FEEDBACK_CYC);
	// A chain end without inputs or a chain too long is a configuration fault
	assign chain_fault = (chain_reg > `CHAIN_MAX) ||
			(chain_reg == 6'h00) ||
			(chain_reg > 6'h01 && !(ctrl_reg[`CTRL_EDM] &&
			ctrl_reg[`CTRL_INPUTS]));
	assign any_fault   = ~supply_ok | st_fail | out_fault | fb_fault | chain_fault;

	// Fault code in priority order; first cause is held until clear
	always @* begin
		fault_next = fault_reg;
		if (fault_reg == `FLT_NONE) begin
			if (!supply_ok)
				fault_next = `FLT_SUPPLY;
			else if (st_fail)
				fault_next = `FLT_SELFTEST;
			else if (out_fault)
				fault_next = `FLT_OUTPUT;
			else if (fb_fault)
				fault_next = `FLT_FEEDBACK;
			else if (chain_fault)
				fault_next = `FLT_CHAIN;
		end else if (ctrl_reg[`CTRL_CLEAR] && !any_fault) begin
			fault_next = `FLT_NONE;
		end
	end

	always @(posedge ref_clk) begin
		if (rst)
			fault_reg <= `FLT_NONE;
		else
			fault_reg <= fault_next;
	end

	// ----------------------------------------
	// Learn request edge
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (rst)
			learn_req_d <= 1'b0;
		else
			learn_req_d <= learn_request_input;
	end

	assign learn_edge = learn_request_input & ~learn_req_d & ctrl_reg[`CTRL_LEARN];

	// ----------------------------------------
	// Zone and output state machine
	// ----------------------------------------
	// Entry needs the safe zone, leaving waits for the limit zone edge:
	// the gap between the two is the hysteresis that stops chatter
	always @* begin
		state_next = state_reg;
		ev_learned = 1'b0;
		case (state_reg)
		S_IDLE: begin
			if (fault_next != `FLT_NONE)
				state_next = S_FAULT;
			else if (learn_edge)
				state_next = S_LEARN;
			else if (inputs_ok && code_ok && zone_safe)
				state_next = S_SAFE;
		end
		S_SAFE: begin
			if (fault_next != `FLT_NONE)
				state_next = S_FAULT;
			else if (!inputs_ok || !code_ok)
				state_next = S_IDLE;
			else if (!zone_safe && zone_limit)
				state_next = S_LIMIT;
			else if (!zone_safe)
				state_next = S_IDLE;
		end
		S_LIMIT: begin
			if (fault_next != `FLT_NONE)
				state_next = S_FAULT;
			else if (!inputs_ok || !code_ok || !zone_limit)
				state_next = S_IDLE;
			else if (zone_safe)
				state_next = S_SAFE;
		end
		S_LEARN: begin
			if (fault_next != `FLT_NONE)
				state_next = S_FAULT;
			else if (actuator_present && zone_safe &&
					actuator_code != code_reg) begin
				state_next = S_IDLE;
				ev_learned = 1'b1;
			end
		end
		S_FAULT: begin
			if (fault_next == `FLT_NONE)
				state_next = S_IDLE;
		end
		default: state_next = S_FAULT;
		endcase
	end

	always @(posedge ref_clk) begin
		if (rst)
			state_reg <= S_IDLE;
		else
			state_reg <= state_next;
	end

	// New code overwrites the old, which is then refused
	always @(posedge ref_clk) begin
		if (rst)
			code_reg <= `CODE_RST;
		else if (ev_learned)
			code_reg <= actuator_code;
	end

	// Outputs and signalling output from flip-flops
	always @(posedge ref_clk) begin
		if (rst) begin
			safety_outputs <= 2'b00;
			signal_output  <= 1'b0;
		end else begin
			safety_outputs <= {2{state_next == S_SAFE || state_next == S_LIMIT}};
			signal_output  <= (state_next == S_SAFE || state_next == S_LIMIT) ^
					ctrl_reg[`CTRL_INVERT];
		end
	end

	// ----------------------------------------
	// Status indicator
	// ----------------------------------------
	led_indicator #(
		.BLINK_CYC (BLINK_CYC)
	) u_led (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.show_green   (state_reg == S_SAFE),
		.show_yellow  (state_reg == S_IDLE),
		.flash_yellow (state_reg == S_LIMIT),
		.show_purple  (state_reg == S_LEARN),
		.show_red     (state_reg == S_FAULT),
		.fault_code   (fault_reg),
		.led_red      (led_red),
		.led_green    (led_green),
		.led_blue     (led_blue)
	);

endmodule

// ### tb/guard_sensor_output_controller_assertions.sv
/*
 Checker for the guard sensor output controller: zone, fault and indicator
 timing at the top ports. Assumes a single ref_clk domain, reset rst.
*/
`timescale 1ns/1ns
module guard_ctrl_checker #(
	parameter FEEDBACK_CYC = 30
) (
	input wire       ref_clk,
	input wire       rst,
	input wire       supply_ok,
	input wire       zone_safe,
	input wire       zone_limit,
	input wire [1:0] output_readback,
	input wire       contactor_feedback_input,
	input wire [1:0] safety_outputs,
	input wire       signal_output,
	input wire       led_red,
	input wire       led_green,
	input wire       led_blue
);
	reg [31:0] fb_cnt_reg;
	reg [31:0] rb_cnt_reg;

	// ----------------------------------------
	// Run-length counters
	// ----------------------------------------
	// Long runs need counters, repetition would unroll too far
	always @(posedge ref_clk) begin
		if (rst || !(safety_outputs[0] && contactor_feedback_input))
			fb_cnt_reg <= 32'h0;
		else
			fb_cnt_reg <= fb_cnt_reg + 32'h1;
		if (rst || safety_outputs == 2'b00 || output_readback == safety_outputs)
			rb_cnt_reg <= 32'h0;
		else
			rb_cnt_reg <= rb_cnt_reg + 32'h1;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_rise_needs_safe: assert property ($rose(safety_outputs[0]) |-> $past(zone_safe))
		else $error("outputs rose without safe zone");
	a_pair_equal: assert property (safety_outputs[1] == safety_outputs[0])
		else $error("output channels differ");
	a_limit_exit: assert property ((safety_outputs[0] && !zone_limit && !zone_safe)
		|=> safety_outputs == 2'b00) else $error("outputs kept outside zone");
	a_idle_hold: assert property ((safety_outputs == 2'b00 && !zone_safe)
		|=> safety_outputs == 2'b00) else $error("outputs on without safe zone");
	a_signal_follows: assert property ($changed(safety_outputs[0]) |-> $changed(signal_output))
		else $error("signal output missed an output change");
	a_supply_off: assert property (!supply_ok |=> safety_outputs == 2'b00)
		else $error("outputs on with supply low");
	a_green_after_on: assert property ($rose(safety_outputs[0])
		|=> led_green && !led_red && !led_blue) else $error("no green after turn on");
	a_feedback_bound: assert property (fb_cnt_reg <= FEEDBACK_CYC + 2)
		else $error("stuck feedback not acted on");
	a_readback_bound: assert property (rb_cnt_reg <= 32'h8)
		else $error("readback mismatch not acted on");
endmodule

bind guard_sensor_output_controller guard_ctrl_checker #(.FEEDBACK_CYC(FEEDBACK_CYC)) u_chk (
	.ref_clk(ref_clk), .rst(rst), .supply_ok(supply_ok), .zone_safe(zone_safe),
	.zone_limit(zone_limit), .output_readback(output_readback),
	.contactor_feedback_input(contactor_feedback_input), .safety_outputs(safety_outputs),
	.signal_output(signal_output), .led_red(led_red), .led_green(led_green),
	.led_blue(led_blue));

// ### tb/contactor_model.sv
/*
 Safety module and contactor pair driven by the safety outputs, with
 output sensing. Assumes bench control of speed and injected faults.
*/
`timescale 1ns/1ns
module contactor_model (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire [1:0] safety_outputs,
	input  wire       short_rb,
	input  wire       weld_open,
	input  wire       slow,
	output reg  [1:0] output_readback,
	output wire       contactor_feedback_input
);
	reg       closed_reg;
	reg [3:0] delay_reg;

	// Sensing lags one cycle; a short pulls it to ground on command
	always @(posedge ref_clk) begin
		output_readback <= short_rb ? 2'b00 : safety_outputs;
	end

	// Pull in only when both channels agree on, drop on any channel off
	always @(posedge ref_clk) begin
		if (rst) begin
			closed_reg <= 1'b0;
			delay_reg <= 4'h0;
		end else if ((&safety_outputs) != closed_reg && !weld_open) begin
			delay_reg <= delay_reg + 4'h1;
			if (delay_reg >= (slow ? 4'h9 : 4'h1)) begin
				closed_reg <= &safety_outputs;
				delay_reg <= 4'h0;
			end
		end else begin
			delay_reg <= 4'h0;
		end
	end

	// Mirror contact reads high while released
	assign contactor_feedback_input = !closed_reg;
endmodule

// ### tb/test_guard_sensor_output_controller.sv
/*
 Self-checking bench: APB tasks and zone, fault and learn sequences.
 Assumes the contactor model and the bound checker.
*/
`timescale 1ns/1ns
`include "guard_ctrl_regs.vh"
module test_guard_sensor_output_controller;
	reg        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, rdata;
	reg        supply_ok = 1'b1, selftest_done = 1'b0, selftest_pass = 1'b0, st_ok = 1'b1;
	reg [1:0]  safety_inputs = 2'b11;
	reg        zone_safe = 1'b0, zone_limit = 1'b0, actuator_present = 1'b0;
	reg        learn_request_input = 1'b0, short_rb = 1'b0, weld_open = 1'b0, slow = 1'b0;
	reg [15:0] actuator_code = 16'h0000;
	reg        perr, seen;
	wire [31:0] prdata;
	wire [1:0] safety_outputs, output_readback;
	wire       pready, pslverr, selftest_req, signal_output, irq, contactor_feedback_input;
	wire       led_red, led_green, led_blue;
	integer    n_mismatch = 0, checked = 0, cycles = 0;

	guard_sensor_output_controller #(
		.SELFTEST_CYC(50),
		.ST_WAIT_CYC(20),
		.FEEDBACK_CYC(30),
		.BLINK_CYC(4)
	) DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply_ok(supply_ok), .selftest_req(selftest_req), .selftest_done(selftest_done),
		.selftest_pass(selftest_pass), .safety_inputs(safety_inputs), .zone_safe(zone_safe),
		.zone_limit(zone_limit), .actuator_present(actuator_present),
		.actuator_code(actuator_code), .output_readback(output_readback),
		.contactor_feedback_input(contactor_feedback_input),
		.learn_request_input(learn_request_input), .safety_outputs(safety_outputs),
		.signal_output(signal_output), .led_red(led_red), .led_green(led_green),
		.led_blue(led_blue), .irq(irq));

	contactor_model partner (.ref_clk(ref_clk), .rst(rst), .safety_outputs(safety_outputs),
		.short_rb(short_rb), .weld_open(weld_open), .slow(slow),
		.output_readback(output_readback), .contactor_feedback_input(contactor_feedback_input));

	// ----------------------------------------
	// Clock, self-test answer, watchdog
	// ----------------------------------------
	always #5 ref_clk = ~ref_clk;
	// Tester answers each request one cycle later; hang cut at 6000
	always @(posedge ref_clk) begin
		selftest_done <= selftest_req;
		selftest_pass <= st_ok;
		cycles = cycles + 1;
		if (cycles == 6000) begin
			n_mismatch = n_mismatch + 1;
			complete_run;
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task complete_run;
		$display("Mismatches %0d of %0d checks", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask
	task check_that(input ok, input string msg);
		checked = checked + 1;
		if (ok !== 1'b1) begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	// Request held until pready is seen at a rising edge
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rdata = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input [11:0] a, input [31:0] m, input [31:0] e, input string msg);
		apb(1'b0, a, 32'h0);
		check_that((rdata & m) === e, msg);
	endtask
	task zone(input s, input l);
		@(posedge ref_clk);
		zone_safe <= s;
		zone_limit <= l;
		actuator_present <= s | l;
		cyc(3);
	endtask
	task watch(input [2:0] p, input integer n);
		seen = 1'b0;
		repeat (n) begin
			@(posedge ref_clk);
			if ({led_red, led_green, led_blue} === p)
				seen = 1'b1;
		end
	endtask
	// Fault latched: outputs off, state fault, first cause code
	task fault_check(input [2:0] code, input integer n);
		cyc(n);
		check_that(safety_outputs === 2'b00, "fault left outputs on");
		rd(`ADDR_STATUS, 32'h1c1f, {19'h0, code, 10'h010}, "fault status");
	endtask
	// Cause removed: stays off until the clear bit is written
	task recover(input [31:0] ctrl);
		cyc(4);
		check_that(safety_outputs === 2'b00, "fault released early");
		apb(1'b1, `ADDR_CTRL, ctrl | 32'h10);
		cyc(4);
		check_that(safety_outputs === 2'b11, "no restart after clear");
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		cyc(10);
		rst <= 1'b0;
		cyc(3);
		rd(`ADDR_CTRL, 32'hffffffff, 32'h4, "ctrl reset");
		rd(`ADDR_CHAIN, 32'hffffffff, 32'h1, "chain reset");
		rd(`ADDR_CODE, 32'hffffffff, 32'h0, "code reset");
		rd(12'h018, 32'hffffffff, 32'h0, "unmapped read");
		check_that(perr === 1'b1, "no error on unmapped");
		check_that({led_red, led_green, led_blue} === 3'b110, "idle not yellow");
		$display("registers done");
		zone(1'b0, 1'b1);
		check_that(safety_outputs === 2'b00, "on from limit zone");
		zone(1'b1, 1'b1);
		check_that(led_green === 1'b1 && led_red === 1'b0, "safe not green");
		rd(`ADDR_STATUS, 32'h3ff, 32'h382, "safe status");
		zone(1'b0, 1'b1);
		rd(`ADDR_STATUS, 32'h31f, 32'h304, "limit status");
		watch(3'b000, 12);
		check_that(seen === 1'b1, "limit not flashing");
		zone(1'b1, 1'b1);
		rd(`ADDR_STATUS, 32'h1f, 32'h2, "back to safe");
		@(posedge ref_clk);
		safety_inputs <= 2'b01;
		cyc(4);
		check_that(safety_outputs === 2'b00, "on with input lost");
		@(posedge ref_clk);
		safety_inputs <= 2'b11;
		cyc(4);
		check_that(safety_outputs === 2'b11, "no restart with inputs");
		zone(1'b0, 1'b1);
		zone(1'b0, 1'b0);
		check_that(safety_outputs === 2'b00, "on after limit exit");
		cyc(2);
		check_that({led_red, led_green, led_blue} === 3'b110, "exit not yellow");
		$display("zones done");
		check_that(irq === 1'b0, "irq while masked");
		apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
		cyc(1);
		check_that(irq === 1'b1, "irq with on event unmasked");
		apb(1'b1, `ADDR_IRQ_STAT, 32'hf);
		cyc(1);
		check_that(irq === 1'b0, "irq after clear");
		zone(1'b1, 1'b1);
		check_that(irq === 1'b1, "no irq on turn on");
		apb(1'b1, `ADDR_IRQ_STAT, 32'hf);
		apb(1'b1, `ADDR_IRQ_MASK, 32'h0);
		$display("interrupt done");
		@(posedge ref_clk);
		supply_ok <= 1'b0;
		fault_check(3'h1, 3);
		watch(3'b100, 40);
		check_that(seen === 1'b1, "fault not red");
		supply_ok <= 1'b1;
		recover(32'h4);
		st_ok <= 1'b0;
		fault_check(3'h2, 80);
		st_ok <= 1'b1;
		recover(32'h4);
		short_rb <= 1'b1;
		fault_check(3'h3, 12);
		short_rb <= 1'b0;
		recover(32'h4);
		$display("faults done");
		apb(1'b1, `ADDR_CTRL, 32'h5);
		slow <= 1'b1;
		zone(1'b0, 1'b1);
		zone(1'b0, 1'b0);
		cyc(15);
		weld_open <= 1'b1;
		zone(1'b1, 1'b1);
		fault_check(3'h4, 45);
		weld_open <= 1'b0;
		recover(32'h5);
		cyc(30);
		check_that(safety_outputs === 2'b11, "slow contactor refused");
		slow <= 1'b0;
		apb(1'b1, `ADDR_CHAIN, 32'h21);
		fault_check(3'h5, 4);
		apb(1'b1, `ADDR_CHAIN, 32'h20);
		recover(32'h5);
		apb(1'b1, `ADDR_CHAIN, 32'h1);
		$display("feedback and chain done");
		zone(1'b0, 1'b1);
		zone(1'b0, 1'b0);
		apb(1'b1, `ADDR_CTRL, 32'h6);
		@(posedge ref_clk);
		learn_request_input <= 1'b1;
		cyc(4);
		check_that({led_red, led_green, led_blue} === 3'b101, "learn not purple");
		rd(`ADDR_STATUS, 32'h1f, 32'h8, "learn state");
		actuator_code <= 16'h5a3c;
		zone(1'b1, 1'b1);
		learn_request_input <= 1'b0;
		rd(`ADDR_CODE, 32'hffff, 32'h5a3c, "code learned");
		rd(`ADDR_IRQ_STAT, 32'h8, 32'h8, "learned event");
		check_that(safety_outputs === 2'b11, "new code refused");
		zone(1'b0, 1'b1);
		zone(1'b0, 1'b0);
		actuator_code <= 16'h0000;
		zone(1'b1, 1'b1);
		cyc(3);
		check_that(safety_outputs === 2'b00, "old code accepted");
		$display("learn done");
		apb(1'b1, `ADDR_CTRL, 32'hc);
		cyc(2);
		check_that(signal_output === 1'b1, "inverted sense not shown");
		$display("invert done");
		complete_run;
	end
endmodule
